//--- src/kbc_irq_pkg.sv
/*
  Package for the host interface interrupt enable block: register
  indices, field positions, reset values, route codes and port structs.
  Assumes a single core-clock domain.
*/
package kbc_irq_pkg;

  // register indices on the core register port
  localparam logic [1:0] ADDR_ENABLES = 2'h0;
  localparam logic [1:0] ADDR_LINECTL = 2'h1;
  localparam logic [1:0] ADDR_ROUTE = 2'h2;
  localparam logic [1:0] ADDR_FLAGS = 2'h3;

  // enable register fields
  localparam int EN_KBD_HOST = 0;
  localparam int EN_MOUSE_HOST = 1;
  localparam int EN_OUT_EMPTY = 2;
  localparam int EN_IN_FULL = 3;
  localparam int EN_PM1_HOST = 4;
  localparam int EN_PM1_OUT_EMPTY = 5;
  localparam int EN_PM1_IN_FULL = 6;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] ENABLES_WMASK = 8'h7F;

  // line control register fields
  localparam int LC_KBD = 0;
  localparam int LC_MOUSE = 1;
  localparam int LC_PM1 = 2;
  localparam int LC_SHAPE_LO = 3;
  localparam int LC_SHAPE_HI = 5;
  localparam int LC_POL = 6;
  localparam logic [7:0] LINECTL_RESET = 8'h07;
  localparam logic [7:0] LINECTL_WMASK = 8'h7F;
  localparam logic [2:0] SHAPE_LEVEL = 3'h0;

  // pm1 routing register
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam int ROUTE_IRQ_LINES = 16;
  localparam logic [4:0] ROUTE_SMI = 5'h10;
  localparam logic [4:0] ROUTE_SCI = 5'h11;

  typedef struct packed {
    logic kbdWrite;
    logic mouseWrite;
    logic pm1Write;
    logic kbOutFull;
    logic kbInFull;
    logic pm1OutFull;
    logic pm1InFull;
    logic pm1Compat;
  } chan_events_s;

  typedef struct packed {
    logic kbdOutEmpty;
    logic kbdInFull;
    logic pm1OutEmpty;
    logic pm1InFull;
  } core_irqs_s;

  typedef struct packed {
    logic [ROUTE_IRQ_LINES-1:0] irqLines;
    logic smi;
    logic sci;
  } pm1_route_s;

endpackage : kbc_irq_pkg

//--- src/host_kbc_interrupt_enables.sv
/*
  Interrupt enable and shaping logic for the keyboard/mouse channel and
  power-management channel 1. Drives host interrupt lines and core
  interrupt unit requests. Assumes buffer flags and write strobes come
  from logic on the same core clock.
*/
// Implementation choices: the plain strobed port and the placing of the registers.
// Notes on behaviour
// RQ1: keyboard line follows direct bit when disabled
// RQ2: keyboard data-out write raises shaped interrupt
// RQ3: mouse line follows direct bit when disabled
// RQ4: mouse data-out write raises shaped interrupt
// RQ5: output-empty core irq while out flag clear
// RQ6: input-full core irq while in flag set
// RQ7: disabled core irq held low
// RQ8: pm1 line follows direct bit when disabled
// RQ9: pm1 data-out write raises shaped interrupt
// RQ10: pm1 interrupt routable to irq, smi, sci
// RQ11: pm1 output-empty core irq while flag clear
// RQ12: pm1 input-full core irq while flag set
// RQ13: reset clears all enable bits
// RQ14: shape zero gives level, follows out flag
// RQ15: nonzero shape gives pulse of coded length
// RQ16: out flag set by write, host read clears
// RQ17: enables read back, top bit reads zero
`timescale 1ns/100ps
`default_nettype none

module host_kbc_interrupt_enables (
  input wire logic clock,
  input wire logic srst,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire kbc_irq_pkg::chan_events_s events,
  input wire logic hostReadOut,
  output logic kbdHostIrq,
  output logic mouseHostIrq,
  output logic pm1HostIrq,
  output kbc_irq_pkg::pm1_route_s pm1Route,
  output kbc_irq_pkg::core_irqs_s coreIrqs,
  output logic outFullFlag
);
  import kbc_irq_pkg::*;

  logic [7:0] enables_q;
  logic [7:0] lineCtl_q;
  logic [7:0] route_q;
  logic outFull_q;
  logic outIsMouse_q;
  logic [2:0] shape;
  logic polarity;
  logic [2:0] kbdCnt_q;
  logic [2:0] mouseCnt_q;
  logic [2:0] pm1Cnt_q;
  logic kbdLine;
  logic mouseLine;
  logic pm1Line;
  logic pm1Gated;

  assign shape = lineCtl_q[LC_SHAPE_HI:LC_SHAPE_LO];
  assign polarity = lineCtl_q[LC_POL];

  // level when shape is zero, else active while pulse counter runs
  function automatic logic shapeLine(input logic lvl, input logic [2:0] cnt,
      input logic [2:0] shp, input logic pol);
    logic act;
    act = (shp == SHAPE_LEVEL) ? lvl : (cnt != 3'h0);
    if (shp == SHAPE_LEVEL) begin
      shapeLine = act ^ pol; // RQ14
    end else begin
      shapeLine = ~(act ^ pol); // RQ15
    end
  endfunction

  function automatic logic [2:0] pulseNext(input logic trig,
      input logic [2:0] cnt, input logic [2:0] shp);
    if (shp == SHAPE_LEVEL) begin
      pulseNext = 3'h0;
    end else if (trig) begin
      pulseNext = shp; // RQ15
    end else if (cnt != 3'h0) begin
      pulseNext = cnt - 3'h1;
    end else begin
      pulseNext = 3'h0;
    end
  endfunction

  // enable register
  always_ff @(posedge clock) begin
    if (srst) begin
      enables_q <= ENABLES_RESET; // RQ13
    end else if (regWrite && regAddr == ADDR_ENABLES) begin
      enables_q <= regWrData & ENABLES_WMASK; // RQ17
    end
  end

  // line control register
  always_ff @(posedge clock) begin
    if (srst) begin
      lineCtl_q <= LINECTL_RESET;
    end else if (regWrite && regAddr == ADDR_LINECTL) begin
      lineCtl_q <= regWrData & LINECTL_WMASK;
    end
  end

  // pm1 route selection
  always_ff @(posedge clock) begin
    if (srst) begin
      route_q <= ROUTE_RESET;
    end else if (regWrite && regAddr == ADDR_ROUTE) begin
      route_q <= {3'h0, regWrData[4:0]};
    end
  end

  // output full flag, write beats a simultaneous host read
  always_ff @(posedge clock) begin
    if (srst) begin
      outFull_q <= 1'b0;
      outIsMouse_q <= 1'b0;
    end else if (events.kbdWrite || events.mouseWrite) begin
      outFull_q <= 1'b1; // RQ16
      outIsMouse_q <= events.mouseWrite;
    end else if (hostReadOut) begin
      outFull_q <= 1'b0; // RQ16
    end
  end

  // pulse counters
  always_ff @(posedge clock) begin
    if (srst) begin
      kbdCnt_q <= 3'h0;
      mouseCnt_q <= 3'h0;
      pm1Cnt_q <= 3'h0;
    end else begin
      kbdCnt_q <= pulseNext(events.kbdWrite, kbdCnt_q, shape); // RQ2
      mouseCnt_q <= pulseNext(events.mouseWrite, mouseCnt_q, shape); // RQ4
      pm1Cnt_q <= pulseNext(events.pm1Write && events.pm1Compat,
        pm1Cnt_q, shape); // RQ9
    end
  end

  assign kbdLine = enables_q[EN_KBD_HOST]
    ? shapeLine(outFull_q && !outIsMouse_q, kbdCnt_q, shape, polarity) // RQ2
    : lineCtl_q[LC_KBD]; // RQ1
  assign mouseLine = enables_q[EN_MOUSE_HOST]
    ? shapeLine(outFull_q && outIsMouse_q, mouseCnt_q, shape, polarity) // RQ4
    : lineCtl_q[LC_MOUSE]; // RQ3
  assign pm1Gated = enables_q[EN_PM1_HOST] && events.pm1Compat;
  assign pm1Line = pm1Gated
    ? shapeLine(events.pm1OutFull, pm1Cnt_q, shape, polarity) // RQ9
    : lineCtl_q[LC_PM1]; // RQ8

  // registered host lines and core requests
  always_ff @(posedge clock) begin
    if (srst) begin
      kbdHostIrq <= 1'b0;
      mouseHostIrq <= 1'b0;
      pm1HostIrq <= 1'b0;
      coreIrqs <= '0;
    end else begin
      kbdHostIrq <= kbdLine;
      mouseHostIrq <= mouseLine;
      pm1HostIrq <= pm1Line;
      coreIrqs.kbdOutEmpty <= enables_q[EN_OUT_EMPTY] && !outFull_q; // RQ5 RQ7
      coreIrqs.kbdInFull <= enables_q[EN_IN_FULL] && events.kbInFull; // RQ6 RQ7
      coreIrqs.pm1OutEmpty <= enables_q[EN_PM1_OUT_EMPTY]
        && events.pm1Compat && !events.pm1OutFull; // RQ11 RQ7
      coreIrqs.pm1InFull <= enables_q[EN_PM1_IN_FULL]
        && events.pm1Compat && events.pm1InFull; // RQ12 RQ7
    end
  end

  // steer pm1 line to one destination, or to none for route codes above ROUTE_SCI
  always_ff @(posedge clock) begin
    if (srst) begin
      pm1Route <= '0;
    end else begin
      pm1Route <= '0;
      if (route_q[4:0] == ROUTE_SMI) begin
        pm1Route.smi <= pm1Line; // RQ10
      end else if (route_q[4:0] == ROUTE_SCI) begin
        pm1Route.sci <= pm1Line; // RQ10
      end else if (route_q[4] == 1'b0) begin
        pm1Route.irqLines[route_q[3:0]] <= pm1Line; // RQ10
      end
    end
  end

  assign outFullFlag = outFull_q;

  // read data one cycle after the strobe; line bits show current pins
  always_ff @(posedge clock) begin
    if (srst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_ENABLES: regRdData <= enables_q & ENABLES_WMASK; // RQ17
        ADDR_LINECTL: regRdData <= {lineCtl_q[7:3], pm1HostIrq,
          mouseHostIrq, kbdHostIrq};
        ADDR_ROUTE: regRdData <= route_q;
        ADDR_FLAGS: regRdData <= {6'h00, events.kbInFull, outFull_q};
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule // host_kbc_interrupt_enables

`default_nettype wire

//--- verification/kbc_host_model.sv
/* far-side model: host reads of the output buffer.
   assumes the block's core clock and reset. */
`timescale 1ns/100ps
`default_nettype none
module kbc_host_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic readReq,
  output logic hostReadOut
);
  always_ff @(posedge clock) begin
    if (srst) hostReadOut <= 1'b0;
    else hostReadOut <= readReq;
  end
endmodule // kbc_host_model
`default_nettype wire

//--- verification/host_kbc_irq_asserts.sv
/* checker on the top ports, with shadow enable and line control.
   assumes a single core clock and srst. */
`timescale 1ns/100ps
`default_nettype none
module kbc_irq_checker import kbc_irq_pkg::*; (
  input wire logic clock,
  input wire logic srst,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire chan_events_s events,
  input wire logic hostReadOut,
  input wire logic kbdHostIrq,
  input wire core_irqs_s coreIrqs,
  input wire logic outFullFlag
);
  logic [7:0] en_q;
  logic [7:0] lc_q;
  always_ff @(posedge clock) begin
    if (srst) en_q <= ENABLES_RESET;
    else if (regWrite && regAddr == ADDR_ENABLES) en_q <= regWrData;
  end
  always_ff @(posedge clock) begin
    if (srst) lc_q <= LINECTL_RESET;
    else if (regWrite && regAddr == ADDR_LINECTL) lc_q <= regWrData;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  property p_in; coreIrqs.kbdInFull ==
    $past(en_q[EN_IN_FULL] & events.kbInFull); endproperty
  a_in: assert property (p_in) else $error("in full irq wrong");
  property p_oe; coreIrqs.kbdOutEmpty ==
    $past(en_q[EN_OUT_EMPTY] & !outFullFlag); endproperty
  a_oe: assert property (p_oe) else $error("out empty irq");
  property p_pmo; coreIrqs.pm1OutEmpty == $past(en_q[EN_PM1_OUT_EMPTY]
    & events.pm1Compat & !events.pm1OutFull); endproperty
  a_pmo: assert property (p_pmo) else $error("pm1 out empty irq");
  property p_set; events.kbdWrite || events.mouseWrite |=> outFullFlag;
  endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_clr; hostReadOut && !events.kbdWrite && !events.mouseWrite
    |=> !outFullFlag; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_pmi; coreIrqs.pm1InFull == $past(en_q[EN_PM1_IN_FULL]
    & events.pm1Compat & events.pm1InFull); endproperty
  a_pmi: assert property (p_pmi) else $error("pm1 in full irq");
  property p_dir; !$past(srst) && !$past(en_q[EN_KBD_HOST]) |->
    kbdHostIrq == $past(lc_q[LC_KBD]); endproperty
  a_dir: assert property (p_dir) else $error("direct line wrong");
  property p_lvl; $past(en_q[0] && lc_q[5:3] == SHAPE_LEVEL && !lc_q[6]
    && !outFullFlag) |-> !kbdHostIrq; endproperty
  a_lvl: assert property (p_lvl) else $error("level line high");
  property p_pls; events.kbdWrite && en_q[0] && !lc_q[6] &&
    lc_q[5:3] != SHAPE_LEVEL |-> ##2 !kbdHostIrq; endproperty
  a_pls: assert property (p_pls) else $error("no pulse");
  c_pls: cover property (events.kbdWrite && lc_q[5:3] != SHAPE_LEVEL);
  c_rd: cover property (hostReadOut && outFullFlag);
  c_pmi: cover property (coreIrqs.pm1InFull);
endmodule // kbc_irq_checker
bind host_kbc_interrupt_enables kbc_irq_checker chk (.clock(clock),
  .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .events(events), .hostReadOut(hostReadOut),
  .kbdHostIrq(kbdHostIrq), .coreIrqs(coreIrqs), .outFullFlag(outFullFlag));
`default_nettype wire

//--- verification/tb_host_kbc_interrupt_enables.sv
/* self-checking bench for the interrupt enable block.
   assumes the far-side model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module tb_host_kbc_interrupt_enables;
  import kbc_irq_pkg::*;
  logic clock = 0, srst = 1, regWrite = 0, regRead = 0, readReq = 0;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWrData = 8'h00, regRdData, en;
  logic kbdIrq, mouseIrq, pm1Irq, outFull, hostReadOut;
  chan_events_s ev = '0;
  pm1_route_s route;
  core_irqs_s core;
  logic [7:0] rt[3] = '{8'h03, 8'h10, 8'h11};
  logic [17:0] ex[3] = '{18'h00020, 18'h00002, 18'h00001};
  int miscompares = 0, compares = 0, n;
  always #20 clock = ~clock;
  host_kbc_interrupt_enables uut (.clock(clock), .srst(srst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .events(ev),
    .hostReadOut(hostReadOut), .kbdHostIrq(kbdIrq), .mouseHostIrq(mouseIrq),
    .pm1HostIrq(pm1Irq), .pm1Route(route), .coreIrqs(core),
    .outFullFlag(outFull));
  kbc_host_model far (.clock(clock), .srst(srst), .readReq(readReq),
    .hostReadOut(hostReadOut));
  task chk(input string s, input logic [17:0] e, input logic [17:0] g);
    compares++;
    if (e !== g) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock); regWrite <= 1; regAddr <= a; regWrData <= d;
    @(posedge clock); regWrite <= 0;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock); regRead <= 1; regAddr <= a;
    @(posedge clock); regRead <= 0;
    @(negedge clock); chk("regRdData", e, regRdData);
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clock);
    @(negedge clock);
  endtask
  task evp(input logic [7:0] m);
    @(posedge clock); ev <= ev | m;
    @(posedge clock); ev <= ev & ~m;
  endtask
  task hr;
    @(posedge clock); readReq <= 1;
    @(posedge clock); readReq <= 0;
    cyc(3);
  endtask
  function automatic core_irqs_s expc(input logic [7:0] e);
    return {e[2], e[3] & ev.kbInFull, e[5] & ev[0] & ~ev.pm1OutFull,
      e[6] & ev[0] & ev.pm1InFull};
  endfunction
  task end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    srst <= 0; ev.pm1Compat <= 1;
    void'($urandom(32'hA9E7C7AF));
    rd(ADDR_ENABLES, ENABLES_RESET);
    rd(ADDR_LINECTL, LINECTL_RESET);
    wr(ADDR_ENABLES, 8'hFF); rd(ADDR_ENABLES, 8'h7F);
    wr(ADDR_ENABLES, 8'h00); wr(ADDR_LINECTL, 8'h05); cyc(3);
    chk("direct lines", 3'h5, {kbdIrq, mouseIrq, pm1Irq});
    $display("test registers and direct lines done");
    wr(ADDR_LINECTL, 8'h00); wr(ADDR_ENABLES, 8'h01); evp(8'h80); cyc(2);
    chk("kbd level", 2'h3, {kbdIrq, outFull});
    rd(ADDR_FLAGS, 8'h01);
    hr; chk("kbd cleared", 2'h0, {kbdIrq, outFull});
    wr(ADDR_ENABLES, 8'h02); evp(8'h40); cyc(2);
    chk("mouse level", 3'h3, {kbdIrq, mouseIrq, outFull});
    hr; wr(ADDR_ENABLES, 8'h01); wr(ADDR_LINECTL, 8'h10); cyc(2);
    chk("pulse idle", 1'b1, kbdIrq);
    n = 0; evp(8'h80);
    repeat (8) begin @(negedge clock); n += (kbdIrq === 1'b0); end
    chk("pulse width", 18'd2, 18'(n));
    hr; $display("test host lines done");
    wr(ADDR_ENABLES, 8'h10); wr(ADDR_LINECTL, 8'h00);
    @(posedge clock); ev.pm1OutFull <= 1;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_ROUTE, rt[i]); cyc(4);
      chk("pm1Route", ex[i], route);
    end
    wr(ADDR_LINECTL, 8'h48); cyc(2);
    chk("pm1 inverted idle", 1'b0, pm1Irq);
    evp(8'h20); cyc(1);
    chk("pm1 inverted pulse", 1'b1, pm1Irq);
    cyc(2);
    chk("pm1 pulse end", 1'b0, pm1Irq);
    $display("test pm1 routing done");
    repeat (100) begin
      @(posedge clock); ev[4:0] <= 5'($urandom);
      en = 8'($urandom); wr(ADDR_ENABLES, en); cyc(2);
      chk("coreIrqs", expc(en), core);
    end
    $display("test core irqs done");
    end_of_test;
  end
endmodule // tb_host_kbc_interrupt_enables
`default_nettype wire
